// ### include/current_detect_pkg.sv
// Constants and types shared by the current-detect configuration block
package current_detect_pkg;

    // Structure
    localparam int CH_COUNT = 3;
    localparam int ADDR_W   = 8;
    localparam int HIT_W    = 8;
    localparam int WIN_W    = 12;
    localparam int IRQ_W    = 3;

    // Register indices; byte address is four times the index
    localparam int IDX_CFG          = 6;
    localparam int IDX_LIMIT_HI     = 7;
    localparam int IDX_LIMIT_LO     = 8;
    localparam int IDX_CH_HP_OFF    = 16;
    localparam int IDX_IRQ_STATUS   = 17;
    localparam int IDX_IRQ_ENABLE   = 18;
    localparam int IDX_IRQ_CLEAR    = 19;
    localparam int IDX_DETECT_STATE = 20;

    localparam logic [ADDR_W-1:0] ADDR_CFG          = 8'(4 * IDX_CFG);
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_HI     = 8'(4 * IDX_LIMIT_HI);
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_LO     = 8'(4 * IDX_LIMIT_LO);
    localparam logic [ADDR_W-1:0] ADDR_CH_HP_OFF    = 8'(4 * IDX_CH_HP_OFF);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = 8'(4 * IDX_IRQ_STATUS);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE   = 8'(4 * IDX_IRQ_ENABLE);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR    = 8'(4 * IDX_IRQ_CLEAR);
    localparam logic [ADDR_W-1:0] ADDR_DETECT_STATE = 8'(4 * IDX_DETECT_STATE);

    // Configuration register fields
    localparam int CFG_EN_BIT     = 0;
    localparam int CFG_WIN_LSB    = 1;
    localparam int CFG_HITS_LSB   = 4;
    localparam int CFG_POLICY_BIT = 7;

    // Lower limit register fields
    localparam int LO_HP_LSB    = 0;
    localparam int LO_LIMIT_LSB = 8;

    // Reset values
    localparam logic [7:0]          CFG_RESET        = 8'h00;
    localparam logic [15:0]         LIMIT_HI_RESET   = 16'h0000;
    localparam logic [7:0]          LIMIT_LO_RESET   = 8'h00;
    localparam logic [3:0]          HP_CODE_RESET    = 4'h0;
    localparam logic [CH_COUNT-1:0] CH_HP_OFF_RESET  = 3'h0;
    localparam logic [IRQ_W-1:0]    IRQ_ENABLE_RESET = 3'h0;

    // Interrupt status bits
    localparam int IRQ_DETECT = 0;
    localparam int IRQ_WINDOW = 1;
    localparam int IRQ_ACCESS = 2;

    // Decoding of selection codes
    localparam logic [HIT_W-1:0] HIT_ONE = 8'h01;
    localparam logic [7:0][WIN_W-1:0] WIN_LEN_TABLE = {
        12'hE00, 12'hA00, 12'h700, 12'h500, 12'h300, 12'h200, 12'h100, 12'h080};
    localparam logic [3:0] HP_BYPASS_CODE = 4'h0;
    localparam logic [4:0] HP_SHIFT_BASE  = 5'h01;
    localparam logic [4:0] HP_SHIFT_NONE  = 5'h00;
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

    typedef enum logic {
        DET_IDLE = 1'b0,
        DET_RUN  = 1'b1
    } detect_state_t;

endpackage

// ### hdl/detect_window_counter.sv
// Counts threshold exceedances over a window of conversion periods
`timescale 1ns/1ps
module detect_window_counter
    import current_detect_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // Settings
    input  wire logic                enable,
    input  wire logic                policy,
    input  wire logic [HIT_W-1:0]    hit_target,
    input  wire logic [WIN_W-1:0]    window_len,
    // Datapath events
    input  wire logic                conv_strobe,
    input  wire logic [CH_COUNT-1:0] exceed,
    // Results
    output logic                     detect_pulse,
    output logic                     window_done,
    output logic [HIT_W-1:0]         hit_count,
    output logic                     running
);

    detect_state_t    state;
    logic [WIN_W-1:0] conv_cnt;
    logic             exceed_now;
    logic             window_end;
    logic             active;

    assign exceed_now = policy ? (&exceed) : (|exceed);
    assign active     = (state == DET_RUN) && enable;
    assign window_end = conv_strobe && (conv_cnt == window_len - 12'h001);
    assign running    = (state == DET_RUN);

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= DET_IDLE;
        end else begin
            case (state)
                DET_IDLE: if (enable) state <= DET_RUN;
                DET_RUN:  if (!enable) state <= DET_IDLE;
                default:  state <= DET_IDLE;
            endcase
        end
    end

    // Hit count saturates so a long window cannot wrap into a false detect
    always_ff @(posedge clk) begin
        if (reset || !active) begin
            conv_cnt  <= '0;
            hit_count <= '0;
        end else if (window_end) begin
            conv_cnt  <= '0;
            hit_count <= '0;
        end else if (conv_strobe) begin
            conv_cnt <= conv_cnt + 12'h001;
            if (exceed_now && hit_count != 8'hFF) begin
                hit_count <= hit_count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            detect_pulse <= 1'b0;
            window_done  <= 1'b0;
        end else begin
            detect_pulse <= active && conv_strobe && exceed_now
                            && ({1'b0, hit_count} + 9'h001 == {1'b0, hit_target});
            window_done  <= active && window_end;
        end
    end

    property p_all_needs_every;
        @(posedge clk) disable iff (reset)
        (active && policy && conv_strobe && !window_end && exceed != 3'h7)
        |=> (hit_count == $past(hit_count));
    endproperty
    a_all_needs_every: assert property (p_all_needs_every)
        else $error("hit counted without all channels exceeding");

    property p_any_needs_one;
        @(posedge clk) disable iff (reset)
        (active && !policy && conv_strobe && !window_end && exceed != 3'h0
         && hit_count != 8'hFF) |=> (hit_count == $past(hit_count) + 8'h01);
    endproperty
    a_any_needs_one: assert property (p_any_needs_one)
        else $error("hit missed for a single exceeding channel");

endmodule

// ### hdl/current_detect_config_regs.sv
// Current-detect and DC-block configuration registers on an Avalon-MM slave
//
// Contract
// - Hit-count code n asks for 2**n exceedances, 1 up to 128; resets to 1.
// - Window code selects 128..3584 conversion periods; resets to 128.
// - Enable bit turns current detection on; off after reset.
// - Upper limit register holds threshold bits 23:8, read/write, reset zero.
// - Lower limit register bits 15:8 hold threshold bits 7:0, reset zero.
// - Highpass code k selects coefficient 2**-(k+1), from 1/4 to 1/65536.
// - Highpass code zero bypasses the DC block on every channel.
// - Policy bit picks any channel (0) or all channels (1) to count a hit.
// - A per-channel off bit bypasses the DC block for that channel alone.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module current_detect_config_regs
    import current_detect_pkg::*;
(
    // Clock and reset
    input  wire logic                CORE_CLK,
    input  wire logic                RESET,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]   ADDRESS,
    input  wire logic                READ,
    input  wire logic                WRITE,
    input  wire logic [31:0]         WRITEDATA,
    input  wire logic [3:0]          BYTEENABLE,
    output logic      [31:0]         READDATA,
    output logic                     WAITREQUEST,
    // Detection datapath events
    input  wire logic                CONV_STROBE,
    input  wire logic [CH_COUNT-1:0] CH_EXCEED,
    // Settings to the datapath
    output logic                     DETECT_ON,
    output logic                     DETECT_CHANNEL_POLICY,
    output logic      [HIT_W-1:0]    HIT_TARGET,
    output logic      [WIN_W-1:0]    WINDOW_LEN,
    output logic      [23:0]         DETECT_LIMIT,
    output logic      [4:0]          HP_SHIFT,
    output logic      [CH_COUNT-1:0] HP_BYPASS,
    // Results
    output logic                     CURRENT_DETECT,
    output logic                     IRQ
);

    logic [7:0]          cfg;
    logic [15:0]         limit_hi;
    logic [7:0]          limit_lo;
    logic [3:0]          hp_code;
    logic [CH_COUNT-1:0] ch_hp_off;
    logic [IRQ_W-1:0]    irq_status;
    logic [IRQ_W-1:0]    irq_enable;
    logic [IRQ_W-1:0]    irq_event;
    logic [IRQ_W-1:0]    irq_clear;

    logic                req;
    logic                wr_take;
    logic                rd_take;
    logic                lane0;
    logic                lane1;
    logic                mapped;
    logic                det_pulse;
    logic                win_done;
    logic [HIT_W-1:0]    hit_count;
    logic                running;

    // Bus handshake: one wait cycle, then a single accept cycle
    assign req     = READ || WRITE;
    assign wr_take = WRITE && !WAITREQUEST;
    assign rd_take = READ && !WAITREQUEST;
    assign lane0   = wr_take && BYTEENABLE[0];
    assign lane1   = wr_take && BYTEENABLE[1];

    always_comb begin
        mapped = 1'b1;
        if (ADDRESS == ADDR_CFG) begin
            mapped = 1'b1;
        end else if (ADDRESS == ADDR_LIMIT_HI) begin
            mapped = 1'b1;
        end else if (ADDRESS == ADDR_LIMIT_LO) begin
            mapped = 1'b1;
        end else if (ADDRESS == ADDR_CH_HP_OFF) begin
            mapped = 1'b1;
        end else if (ADDRESS == ADDR_IRQ_STATUS) begin
            mapped = 1'b1;
        end else if (ADDRESS == ADDR_IRQ_ENABLE) begin
            mapped = 1'b1;
        end else if (ADDRESS == ADDR_IRQ_CLEAR) begin
            mapped = 1'b1;
        end else if (ADDRESS == ADDR_DETECT_STATE) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            WAITREQUEST <= 1'b1;
        end else if (req && WAITREQUEST) begin
            WAITREQUEST <= 1'b0;
        end else begin
            WAITREQUEST <= 1'b1;
        end
    end

    // Read data is latched in the wait cycle and stands through the accept cycle
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            READDATA <= RD_UNMAPPED;
        end else if (READ && WAITREQUEST) begin
            if (ADDRESS == ADDR_CFG) begin
                READDATA <= {24'h000000, cfg};
            end else if (ADDRESS == ADDR_LIMIT_HI) begin
                READDATA <= {16'h0000, limit_hi};
            end else if (ADDRESS == ADDR_LIMIT_LO) begin
                READDATA <= {16'h0000, limit_lo, 4'h0, hp_code};
            end else if (ADDRESS == ADDR_CH_HP_OFF) begin
                READDATA <= {29'h00000000, ch_hp_off};
            end else if (ADDRESS == ADDR_IRQ_STATUS) begin
                READDATA <= {29'h00000000, irq_status};
            end else if (ADDRESS == ADDR_IRQ_ENABLE) begin
                READDATA <= {29'h00000000, irq_enable};
            end else if (ADDRESS == ADDR_DETECT_STATE) begin
                READDATA <= {23'h000000, running, hit_count};
            end else begin
                READDATA <= RD_UNMAPPED;
            end
        end
    end

    // Configuration: bits above 7 are outside this block and read zero
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            cfg <= CFG_RESET;
        end else if (lane0 && ADDRESS == ADDR_CFG) begin
            cfg <= WRITEDATA[7:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            limit_hi <= LIMIT_HI_RESET;
        end else if (ADDRESS == ADDR_LIMIT_HI) begin
            if (lane0) begin
                limit_hi[7:0] <= WRITEDATA[7:0];
            end
            if (lane1) begin
                limit_hi[15:8] <= WRITEDATA[15:8];
            end
        end
    end

    // Written bits 7:4 are dropped, so a careless write cannot disturb them
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            limit_lo <= LIMIT_LO_RESET;
            hp_code  <= HP_CODE_RESET;
        end else if (ADDRESS == ADDR_LIMIT_LO) begin
            if (lane0) begin
                hp_code <= WRITEDATA[LO_HP_LSB +: 4];
            end
            if (lane1) begin
                limit_lo <= WRITEDATA[LO_LIMIT_LSB +: 8];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ch_hp_off  <= CH_HP_OFF_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
        end else if (lane0 && ADDRESS == ADDR_CH_HP_OFF) begin
            ch_hp_off <= WRITEDATA[CH_COUNT-1:0];
        end else if (lane0 && ADDRESS == ADDR_IRQ_ENABLE) begin
            irq_enable <= WRITEDATA[IRQ_W-1:0];
        end
    end

    // Decoded settings, one flop stage behind the registers
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            DETECT_ON             <= 1'b0;
            DETECT_CHANNEL_POLICY <= 1'b0;
            HIT_TARGET            <= HIT_ONE;
            WINDOW_LEN            <= WIN_LEN_TABLE[0];
            DETECT_LIMIT          <= 24'h000000;
            HP_SHIFT              <= HP_SHIFT_NONE;
        end else begin
            DETECT_ON             <= cfg[CFG_EN_BIT];
            DETECT_CHANNEL_POLICY <= cfg[CFG_POLICY_BIT];
            HIT_TARGET            <= HIT_ONE << cfg[CFG_HITS_LSB +: 3];
            WINDOW_LEN            <= WIN_LEN_TABLE[cfg[CFG_WIN_LSB +: 3]];
            DETECT_LIMIT          <= {limit_hi, limit_lo};
            if (hp_code == HP_BYPASS_CODE) begin
                HP_SHIFT <= HP_SHIFT_NONE;
            end else begin
                HP_SHIFT <= {1'b0, hp_code} + HP_SHIFT_BASE;
            end
        end
    end

    generate
        for (genvar c = 0; c < CH_COUNT; c++) begin : g_bypass
            always_ff @(posedge CORE_CLK) begin
                if (RESET) begin
                    HP_BYPASS[c] <= 1'b1;
                end else begin
                    HP_BYPASS[c] <= (hp_code == HP_BYPASS_CODE) || ch_hp_off[c];
                end
            end
        end
    endgenerate

    detect_window_counter u_counter (
        .clk          (CORE_CLK),
        .reset        (RESET),
        .enable       (DETECT_ON),
        .policy       (DETECT_CHANNEL_POLICY),
        .hit_target   (HIT_TARGET),
        .window_len   (WINDOW_LEN),
        .conv_strobe  (CONV_STROBE),
        .exceed       (CH_EXCEED),
        .detect_pulse (det_pulse),
        .window_done  (win_done),
        .hit_count    (hit_count),
        .running      (running)
    );

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            CURRENT_DETECT <= 1'b0;
        end else begin
            CURRENT_DETECT <= det_pulse;
        end
    end

    // Interrupts: a new event beats a clear in the same cycle
    assign irq_event[IRQ_DETECT] = det_pulse;
    assign irq_event[IRQ_WINDOW] = win_done;
    assign irq_event[IRQ_ACCESS] = (wr_take || rd_take) && !mapped;

    generate
        for (genvar b = 0; b < IRQ_W; b++) begin : g_irq
            assign irq_clear[b] = lane0 && (ADDRESS == ADDR_IRQ_CLEAR) && WRITEDATA[b];
            always_ff @(posedge CORE_CLK) begin
                if (RESET) begin
                    irq_status[b] <= 1'b0;
                end else if (irq_event[b]) begin
                    irq_status[b] <= 1'b1;
                end else if (irq_clear[b]) begin
                    irq_status[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // Registered output costs one cycle of interrupt latency
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_enable);
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    property p_bus_answer;
        req && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not one cycle after request");

    property p_detect_off_after_reset;
        $fell(RESET) |-> !DETECT_ON [*2];
    endproperty
    a_detect_off_after_reset: assert property (p_detect_off_after_reset)
        else $error("detection on right after reset");

    property p_hit_target;
        (lane0 && ADDRESS == ADDR_CFG)
        |=> ##1 (HIT_TARGET == (HIT_ONE << $past(WRITEDATA[6:4], 2)));
    endproperty
    a_hit_target: assert property (p_hit_target)
        else $error("hit target does not follow written code");

    property p_window_max;
        (lane0 && ADDRESS == ADDR_CFG && WRITEDATA[3:1] == 3'h7) |=> ##1 (WINDOW_LEN == 12'hE00);
    endproperty
    a_window_max: assert property (p_window_max)
        else $error("window code 7 not 3584 periods");

    property p_limit_upper;
        (lane0 && lane1 && ADDRESS == ADDR_LIMIT_HI)
        |=> ##1 (DETECT_LIMIT[23:8] == $past(WRITEDATA[15:0], 2));
    endproperty
    a_limit_upper: assert property (p_limit_upper)
        else $error("upper limit bits not taken");

    property p_limit_lower;
        (lane1 && ADDRESS == ADDR_LIMIT_LO)
        |=> ##1 (DETECT_LIMIT[7:0] == $past(WRITEDATA[15:8], 2));
    endproperty
    a_limit_lower: assert property (p_limit_lower)
        else $error("lower limit bits not taken");

    property p_hp_shift;
        (hp_code != HP_BYPASS_CODE) |=> (HP_SHIFT == {1'b0, $past(hp_code)} + HP_SHIFT_BASE);
    endproperty
    a_hp_shift: assert property (p_hp_shift)
        else $error("highpass shift wrong for code");

    property p_hp_bypass_all;
        (hp_code == HP_BYPASS_CODE) |=> (HP_BYPASS == 3'h7) && (HP_SHIFT == HP_SHIFT_NONE);
    endproperty
    a_hp_bypass_all: assert property (p_hp_bypass_all)
        else $error("code zero did not bypass all channels");

    property p_reserved_zero;
        rd_take && ADDRESS == ADDR_LIMIT_LO |-> READDATA[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_channel_off;
        (hp_code != HP_BYPASS_CODE) |=> (HP_BYPASS == $past(ch_hp_off));
    endproperty
    a_channel_off: assert property (p_channel_off)
        else $error("per-channel bypass does not follow off bits");

    property p_irq_level;
        (irq_status & irq_enable) != 3'h0 |=> IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt not raised for enabled status");

    c_write: cover property (wr_take);
    c_read: cover property (rd_take);
    c_detect: cover property (CURRENT_DETECT);
    c_irq: cover property ($rose(IRQ));

endmodule

// ### verification/host_bus_model.sv
// Host controller model driving the Avalon-MM register bus
`timescale 1ns/1ps
module host_bus_model
    import current_detect_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Avalon-MM master
    output logic      [ADDR_W-1:0] address,
    output logic                   read,
    output logic                   write,
    output logic      [31:0]       writedata,
    output logic      [3:0]        byteenable,
    input  wire logic              waitrequest
);
    initial begin
        address    = '0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = '0;
        byteenable = 4'h0;
    end

    // One request at a time, held until waitrequest is sampled low
    task automatic access(input logic [ADDR_W-1:0] a, input logic is_wr,
                          input logic [31:0] d, input logic [3:0] be, input logic raw);
        @(posedge clk);
        address    <= a;
        read       <= !is_wr;
        write      <= is_wr;
        byteenable <= be;
        writedata  <= (a == ADDR_LIMIT_LO && !raw) ? (d & 32'hFFFF_FF0F) : d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read       <= 1'b0;
        write      <= 1'b0;
        // Stale data must not look valid once released
        writedata  <= ~writedata;
    endtask
endmodule

// ### verification/current_detect_config_regs_tb.sv
// Self-checking bench for the current-detect configuration registers
`timescale 1ns/1ps
module current_detect_config_regs_tb;
    import current_detect_pkg::*;
    logic                CORE_CLK, RESET, READ, WRITE, WAITREQUEST;
    logic                CONV_STROBE, DETECT_ON, DETECT_CHANNEL_POLICY;
    logic                CURRENT_DETECT, IRQ;
    logic [ADDR_W-1:0]   ADDRESS;
    logic [31:0]         WRITEDATA, READDATA;
    logic [3:0]          BYTEENABLE;
    logic [CH_COUNT-1:0] CH_EXCEED, HP_BYPASS;
    logic [HIT_W-1:0]    HIT_TARGET;
    logic [WIN_W-1:0]    WINDOW_LEN;
    logic [23:0]         DETECT_LIMIT;
    logic [4:0]          HP_SHIFT;
    logic [31:0]         exp_q[$];
    logic [11:0]         win_len [8] = '{12'h080, 12'h100, 12'h200, 12'h300,
                                         12'h500, 12'h700, 12'hA00, 12'hE00};
    logic [15:0]         hi;
    logic [7:0]          lo8;
    logic [2:0]          code3;
    logic [3:0]          code4;
    int                  fails, num_checks, detects, seed;

    host_bus_model host (.clk(CORE_CLK), .address(ADDRESS), .read(READ), .write(WRITE),
        .writedata(WRITEDATA), .byteenable(BYTEENABLE), .waitrequest(WAITREQUEST));

    current_detect_config_regs uut (.CORE_CLK(CORE_CLK), .RESET(RESET), .ADDRESS(ADDRESS),
        .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
        .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .CONV_STROBE(CONV_STROBE),
        .CH_EXCEED(CH_EXCEED), .DETECT_ON(DETECT_ON),
        .DETECT_CHANNEL_POLICY(DETECT_CHANNEL_POLICY), .HIT_TARGET(HIT_TARGET),
        .WINDOW_LEN(WINDOW_LEN), .DETECT_LIMIT(DETECT_LIMIT), .HP_SHIFT(HP_SHIFT),
        .HP_BYPASS(HP_BYPASS), .CURRENT_DETECT(CURRENT_DETECT), .IRQ(IRQ));

    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        host.access(a, 1'b1, d, 4'h3, 1'b0);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.access(a, 1'b0, 32'h0000_0000, 4'hF, 1'b0);
    endtask

    // Settings outputs lag the accepting edge by one more cycle
    task automatic settle();
        repeat (2) @(posedge CORE_CLK);
    endtask

    task automatic strobes(input int n, input logic [2:0] ex);
        repeat (n) begin
            @(posedge CORE_CLK);
            CONV_STROBE <= 1'b1;
            CH_EXCEED   <= ex;
            @(posedge CORE_CLK);
            CONV_STROBE <= 1'b0;
        end
        repeat (4) @(posedge CORE_CLK);
    endtask

    // Read data taken at the edge where the read is accepted
    always @(posedge CORE_CLK) begin
        if (READ === 1'b1 && WAITREQUEST === 1'b0) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("[FAIL] readdata expected none seen %h", READDATA);
            end else
                check("readdata", exp_q.pop_front(), READDATA);
        end
    end

    always @(posedge CORE_CLK) begin
        if (CURRENT_DETECT === 1'b1)
            detects++;
    end

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        fails++;
        finish_test();
    end

    initial begin
        seed        = 32'h7D59;
        RESET       = 1'b1;
        CONV_STROBE = 1'b0;
        CH_EXCEED   = 3'h0;
        repeat (16) @(posedge CORE_CLK);
        RESET <= 1'b0;
        check("hit_target", 32'h1, 32'(HIT_TARGET));
        check("window_len", 32'h80, 32'(WINDOW_LEN));
        check("detect_on", 32'h0, 32'(DETECT_ON));
        check("limit", 32'h0, 32'(DETECT_LIMIT));
        check("hp_bypass", 32'h7, {HP_SHIFT, 24'h0, HP_BYPASS});
        rd(ADDR_CFG, 32'h0);
        rd(ADDR_LIMIT_HI, 32'h0);
        rd(ADDR_LIMIT_LO, 32'h0);
        rd(ADDR_CH_HP_OFF, 32'h0);
        for (int c = 0; c < 8; c++) begin
            code3 = c[2:0];
            wr(ADDR_CFG, 32'h0000_FF00 | (32'(code3) << 4) | (32'(code3) << 1));
            settle();
            check("hit_target", 32'h1 << code3, 32'(HIT_TARGET));
            check("window_len", 32'(win_len[code3]), 32'(WINDOW_LEN));
            rd(ADDR_CFG, (32'(code3) << 4) | (32'(code3) << 1));
        end
        hi  = 16'($random(seed));
        lo8 = 8'($random(seed));
        wr(ADDR_LIMIT_HI, 32'(hi));
        wr(ADDR_LIMIT_LO, {16'h0, lo8, 8'h00});
        settle();
        check("limit", {8'h0, hi, lo8}, 32'(DETECT_LIMIT));
        rd(ADDR_LIMIT_HI, 32'(hi));
        host.access(ADDR_LIMIT_LO, 1'b1, {16'h0, lo8, 8'hF3}, 4'h3, 1'b1);
        rd(ADDR_LIMIT_LO, {16'h0, lo8, 8'h03});
        host.access(ADDR_LIMIT_HI, 1'b1, 32'h0000_5A5A, 4'h1, 1'b0);
        rd(ADDR_LIMIT_HI, {16'h0, hi[15:8], 8'h5A});
        for (int k = 0; k < 16; k++) begin
            code4 = k[3:0];
            wr(ADDR_LIMIT_LO, {16'h0, lo8, 4'h0, code4});
            settle();
            check("hp_shift", (code4 == 4'h0) ? 32'h0 : 32'(code4) + 32'h1, 32'(HP_SHIFT));
            check("hp_bypass", (code4 == 4'h0) ? 32'h7 : 32'h0, 32'(HP_BYPASS));
        end
        wr(ADDR_CH_HP_OFF, 32'h2);
        settle();
        check("hp_bypass", 32'h2, 32'(HP_BYPASS));
        rd(ADDR_CH_HP_OFF, 32'h2);
        detects = 0;
        wr(ADDR_CFG, 32'h11);
        settle();
        check("detect_on", 32'h1, 32'(DETECT_ON));
        strobes(1, 3'b001);
        check("detects", 32'h0, 32'(detects));
        strobes(1, 3'b001);
        check("detects", 32'h1, 32'(detects));
        rd(ADDR_DETECT_STATE, 32'h102);
        wr(ADDR_CFG, 32'h10);
        strobes(3, 3'b111);
        check("detects", 32'h1, 32'(detects));
        rd(ADDR_DETECT_STATE, 32'h0);
        wr(ADDR_CFG, 32'h91);
        settle();
        check("policy", 32'h1, 32'(DETECT_CHANNEL_POLICY));
        strobes(2, 3'b011);
        check("detects", 32'h1, 32'(detects));
        strobes(2, 3'b111);
        check("detects", 32'h2, 32'(detects));
        wr(ADDR_CFG, 32'h0);
        rd(ADDR_IRQ_STATUS, 32'h1);
        // Window end lands on the 128th strobe, not one earlier
        wr(ADDR_CFG, 32'h1);
        settle();
        strobes(127, 3'h0);
        rd(ADDR_IRQ_STATUS, 32'h1);
        strobes(1, 3'h0);
        rd(ADDR_IRQ_STATUS, 32'h3);
        wr(ADDR_CFG, 32'h0);
        wr(ADDR_IRQ_CLEAR, 32'h7);
        wr(ADDR_IRQ_ENABLE, 32'h4);
        rd(ADDR_IRQ_STATUS, 32'h0);
        rd(8'hFC, 32'h0);
        settle();
        check("irq", 32'h1, 32'(IRQ));
        rd(ADDR_IRQ_STATUS, 32'h4);
        wr(ADDR_IRQ_ENABLE, 32'h0);
        settle();
        check("irq", 32'h0, 32'(IRQ));
        wr(ADDR_IRQ_CLEAR, 32'h4);
        rd(ADDR_IRQ_STATUS, 32'h0);
        rd(ADDR_IRQ_CLEAR, 32'h0);
        repeat (4) @(posedge CORE_CLK);
        finish_test();
    end
endmodule
